// *** logic/utx_pkg.sv ***
// shared constants and types for the cell transmit path, both link ends
package utx_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_CLK_PERIOD_NS = 800;
  localparam int LINK_DIV_CYCLES = LINK_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] LINK_RISE_CNT = 3'(LINK_DIV_CYCLES / 2 - 1);
  localparam logic [2:0] LINK_FALL_CNT = 3'(LINK_DIV_CYCLES - 1);
  localparam logic [5:0] CELL_FIRST_IDX = 6'h00;
  localparam logic [5:0] HEC_IDX = 6'h04;
  localparam logic [5:0] CELL_LAST_IDX = 6'h34;
  localparam logic [4:0] NULL_ADDR = 5'h1f;
  localparam logic [7:0] HEC_COSET = 8'h55;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] HEC_ERR_MASK = 8'h01;
  localparam logic [31:0] IDLE_HEADER = 32'h0000_0001;
  localparam logic [7:0] IDLE_PAYLOAD = 8'h6a;
  localparam int SCR_LEN = 43;
  localparam int NUM_PORTS = 8;
  localparam int NUM_DIRECT = 4;
  localparam int MEM_AW = 11;
  localparam logic [2:0] DEPTH_MIN = 3'h2;
  localparam logic [2:0] DEPTH_MID = 3'h3;
  localparam logic [2:0] DEPTH_MAX = 3'h4;
  // controller register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HDR = 8'h04;
  localparam logic [7:0] REG_SEED = 8'h08;
  localparam logic [7:0] REG_GO = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_PORT_LSB = 0;
  localparam int CTRL_DIRECT_BIT = 8;
  localparam int CTRL_ODD_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] HDR_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    ATM_IDLE,
    ATM_POLL,
    ATM_WAIT,
    ATM_SEL,
    ATM_XFER,
    ATM_END
  } utx_atm_state_e;
endpackage : utx_pkg

// *** logic/utx_link_if.sv ***
// cell transmit link between the layer controller and the transmit port group
`timescale 1ns/1ps
interface utx_link_if;
  logic ut_clk;
  logic [4:0] ut_addr;
  logic ut_enb_n;
  logic ut_soc;
  logic [7:0] ut_data;
  logic ut_prty;
  logic ut_clav;
  logic ut_clav_oe_n;
  logic [3:0] ut_clav_direct;
  logic ut_clav_level;
  // shared cell-available line: undriven reads low here
  assign ut_clav_level = ~ut_clav_oe_n & ut_clav;
  modport atm (
    output ut_clk, ut_addr, ut_enb_n, ut_soc, ut_data, ut_prty,
    input ut_clav_level, ut_clav_direct
  );
  modport phy (
    input ut_clk, ut_addr, ut_enb_n, ut_soc, ut_data, ut_prty,
    output ut_clav, ut_clav_oe_n, ut_clav_direct
  );
endinterface : utx_link_if

// *** logic/utx_cell_store.sv ***
// cell byte store shared by all ports: one write port, one asynchronous read port
`timescale 1ns/1ps
module utx_cell_store
  import utx_pkg::*;
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [MEM_AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [MEM_AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_addr_in];
endmodule : utx_cell_store

// *** logic/utx_phy_end.sv ***
// transmit port group: link receive, per-port cell fifo, header check, idle cells, scrambling
`timescale 1ns/1ps
// Functional notes
// - only one shared cell-available line polling
// - eight ports answer one selectable address range
// - each group on bus gets distinct range
// - per-port fifo depth two, three or four
// - polled port with room asserts cell-available
// - start-of-cell marks first byte of cell
// - new start-of-cell discards partial cell, realigns
// - cell-available driven cycle after address
// - selection latched only while enable deasserted
// - controller polls at most 31 ports
// - back-to-back cells to same port accepted
// - octet 48 poll of active port means next
// - controller repeats address before enabling after pause
// - mid-cell pause re-presents previous port address
// - direct mode: four continuous cell-available lines
// - direct mode ranges of four ports
// - another port's address in a pause drops suspended cell, direct mode too
// - header check byte passed or computed, coset optional
// - header check is crc-8, poly x8+x2+x+1
// - idle cells with valid check, own coset bit
// - payload self-synchronising x43+1 scrambling, header clear
// - periodic header check errors, on/off cell counts
// - parity checked odd/even, flagged per port
module utx_phy_end
  import utx_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  utx_link_if.phy link,
  input wire logic [1:0] range_sel_in,
  input wire logic [1:0] depth_sel_in,
  input wire logic direct_status_mode_in,
  input wire logic transmit_parity_select_in,
  input wire logic [7:0] parity_error_clear_in,
  input wire logic hec_insert_enable_in,
  input wire logic hec_coset_enable_in,
  input wire logic idle_cell_coset_select_in,
  input wire logic payload_scramble_enable_in,
  input wire logic hec_error_insert_enable_in,
  input wire logic [7:0] hec_error_pattern_periods_on_in,
  input wire logic [7:0] hec_error_pattern_periods_off_in,
  input wire logic rd_req_in,
  input wire logic [2:0] rd_port_in,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  output logic tx_soc_out,
  output logic [7:0] port_status_parity_out
);
  typedef struct packed {
    logic [16:0] s1;
    logic [16:0] s2;
    logic clk_prev;
    logic [2:0] sel_port;
    logic sel_ok;
    logic wr_act;
    logic [5:0] wr_idx;
    logic [NUM_PORTS-1:0][2:0] cnt;
    logic [NUM_PORTS-1:0][1:0] wptr;
    logic [NUM_PORTS-1:0][1:0] rptr;
    logic [NUM_PORTS-1:0][5:0] rd_idx;
    logic [NUM_PORTS-1:0] rd_idle;
    logic [NUM_PORTS-1:0] rd_err;
    logic [NUM_PORTS-1:0][7:0] crc;
    logic [NUM_PORTS-1:0][SCR_LEN-1:0] scr;
    logic err_on;
    logic [7:0] err_cnt;
    logic clav;
    logic clav_oe_n;
    logic [NUM_DIRECT-1:0] clav_dir;
    logic [7:0] perr;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_soc;
  } utx_phy_state_s;

  utx_phy_state_s q;
  utx_phy_state_s d;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  logic [7:0] rd_data;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return r;
  endfunction : crc_step

  // returns {new scrambler state, scrambled byte}; output bits feed back, msb first
  function automatic logic [SCR_LEN+7:0] scr_step(input logic [SCR_LEN-1:0] s, input logic [7:0] b);
    logic [SCR_LEN-1:0] st;
    logic [7:0] o;
    st = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = b[i] ^ st[SCR_LEN-1];
      st = {st[SCR_LEN-2:0], o[i]};
    end
    return {st, o};
  endfunction : scr_step

  utx_cell_store u_store (
    .clk_in(clk_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(q.s2[8:1]),
    .rd_addr_in(rd_addr),
    .rd_data_out(rd_data)
  );

  always_comb
  begin
    logic lk_clk;
    logic [4:0] lk_addr;
    logic lk_enb_n;
    logic lk_soc;
    logic [7:0] lk_data;
    logic lk_prty;
    logic rise;
    logic in_rng;
    logic [2:0] port;
    logic [2:0] dep;
    logic [NUM_PORTS-1:0] inc;
    logic [NUM_PORTS-1:0] dec;
    logic [7:0] perr_set;
    logic [2:0] rp;
    logic [5:0] ri;
    logic idle;
    logic e;
    logic [7:0] src;
    logic [7:0] hec;
    logic [SCR_LEN+7:0] sr;
    d = q;
    in_rng = 1'b0;
    src = 8'h00;
    hec = 8'h00;
    sr = '0;
    {lk_clk, lk_addr, lk_enb_n, lk_soc, lk_data, lk_prty} = q.s2;
    rise = lk_clk & ~q.clk_prev;
    // every link pin, its clock included, passes two flip-flops before use
    d.s1 = {link.ut_clk, link.ut_addr, link.ut_enb_n, link.ut_soc, link.ut_data, link.ut_prty};
    d.s2 = q.s1;
    d.clk_prev = lk_clk;
    dep = (depth_sel_in == 2'h0) ? DEPTH_MIN : (depth_sel_in == 2'h1) ? DEPTH_MID : DEPTH_MAX;
    port = lk_addr[2:0];
    if (direct_status_mode_in)
    begin
      in_rng = (lk_addr[4:3] == range_sel_in) && !lk_addr[2];
    end
    else
    begin
      in_rng = (lk_addr[4:3] == range_sel_in) && (lk_addr != NULL_ADDR);
    end
    inc = '0;
    dec = '0;
    perr_set = 8'h00;
    wr_en = 1'b0;
    wr_addr = {q.sel_port, q.wptr[q.sel_port], q.wr_idx};
    if (rise)
    begin
      // shared line, driven only for our own addresses; tri-state otherwise
      d.clav_oe_n = ~in_rng;
      if (!in_rng)
      begin
        d.clav = 1'b0;
      end
      else if (q.wr_act && port == q.sel_port)
      begin
        d.clav = (3'(q.cnt[port] + 3'h1) < dep);
      end
      else
      begin
        d.clav = (q.cnt[port] < dep);
      end
      if (lk_enb_n)
      begin
        // a pause with another port's address drops the partial cell
        if (!in_rng || port != q.sel_port)
        begin
          d.wr_act = 1'b0;
        end
        d.sel_ok = in_rng;
        d.sel_port = port;
      end
      else if (q.sel_ok)
      begin
        if ((^lk_data) ^ transmit_parity_select_in ^ lk_prty)
        begin
          perr_set[q.sel_port] = 1'b1;
        end
        if (lk_soc)
        begin
          // restart on every start-of-cell; a full fifo refuses the cell
          d.wr_act = (q.cnt[q.sel_port] < dep);
          wr_en = d.wr_act;
          wr_addr = {q.sel_port, q.wptr[q.sel_port], CELL_FIRST_IDX};
          d.wr_idx = 6'(CELL_FIRST_IDX + 6'h1);
        end
        else if (q.wr_act)
        begin
          wr_en = 1'b1;
          d.wr_idx = 6'(q.wr_idx + 6'h1);
          if (q.wr_idx == CELL_LAST_IDX)
          begin
            inc[q.sel_port] = 1'b1;
            d.wr_act = 1'b0;
            d.wptr[q.sel_port] = (3'(q.wptr[q.sel_port]) + 3'h1 >= dep) ? 2'h0 : 2'(q.wptr[q.sel_port] + 2'h1);
          end
        end
      end
    end
    for (int i = 0; i < NUM_DIRECT; i++)
    begin
      d.clav_dir[i] = direct_status_mode_in && (q.cnt[i] < dep);
    end
    // read side: one byte per request
    rp = rd_port_in;
    ri = q.rd_idx[rp];
    rd_addr = {rp, q.rptr[rp], ri};
    idle = (ri == CELL_FIRST_IDX) ? (q.cnt[rp] == 3'h0) : q.rd_idle[rp];
    e = q.rd_err[rp];
    d.tx_valid = 1'b0;
    d.tx_soc = 1'b0;
    if (rd_req_in)
    begin
      if (ri == CELL_FIRST_IDX)
      begin
        d.rd_idle[rp] = idle;
        d.crc[rp] = 8'h00;
        e = 1'b0;
        if (!hec_error_insert_enable_in || hec_error_pattern_periods_on_in == 8'h00)
        begin
          d.err_on = 1'b1;
          d.err_cnt = 8'h00;
        end
        else if (q.err_on)
        begin
          e = 1'b1;
          d.err_cnt = 8'(q.err_cnt + 8'h1);
          if (8'(q.err_cnt + 8'h1) >= hec_error_pattern_periods_on_in && hec_error_pattern_periods_off_in != 8'h00)
          begin
            d.err_on = 1'b0;
            d.err_cnt = 8'h00;
          end
        end
        else
        begin
          d.err_cnt = 8'(q.err_cnt + 8'h1);
          if (8'(q.err_cnt + 8'h1) >= hec_error_pattern_periods_off_in)
          begin
            d.err_on = 1'b1;
            d.err_cnt = 8'h00;
          end
        end
        d.rd_err[rp] = e;
      end
      if (idle)
      begin
        src = (ri < HEC_IDX) ? IDLE_HEADER[8'(31 - 8 * ri) -: 8] : IDLE_PAYLOAD;
      end
      else
      begin
        src = rd_data;
      end
      d.tx_byte = src;
      if (ri < HEC_IDX)
      begin
        d.crc[rp] = crc_step(d.crc[rp], src);
      end
      else if (ri == HEC_IDX)
      begin
        hec = q.crc[rp] ^ (((idle ? idle_cell_coset_select_in : hec_coset_enable_in)) ? HEC_COSET : 8'h00);
        d.tx_byte = ((idle || hec_insert_enable_in) ? hec : src) ^ (e ? HEC_ERR_MASK : 8'h00);
      end
      else if (payload_scramble_enable_in)
      begin
        sr = scr_step(q.scr[rp], src);
        d.scr[rp] = sr[SCR_LEN+7:8];
        d.tx_byte = sr[7:0];
      end
      d.tx_valid = 1'b1;
      d.tx_soc = (ri == CELL_FIRST_IDX);
      if (ri == CELL_LAST_IDX)
      begin
        d.rd_idx[rp] = CELL_FIRST_IDX;
        if (!idle)
        begin
          dec[rp] = 1'b1;
          d.rptr[rp] = (3'(q.rptr[rp]) + 3'h1 >= dep) ? 2'h0 : 2'(q.rptr[rp] + 2'h1);
        end
      end
      else
      begin
        d.rd_idx[rp] = 6'(ri + 6'h1);
      end
    end
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      d.cnt[i] = 3'(q.cnt[i] + {2'h0, inc[i]} - {2'h0, dec[i]});
    end
    // a parity error arriving with its clear still sets the flag
    d.perr = (q.perr & ~parity_error_clear_in) | perr_set;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '0;
      q.clav_oe_n <= 1'b1;
      q.err_on <= 1'b1;
      q.s1[10] <= 1'b1;
      q.s2[10] <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.ut_clav = q.clav;
  assign link.ut_clav_oe_n = q.clav_oe_n;
  assign link.ut_clav_direct = q.clav_dir;
  assign tx_byte_out = q.tx_byte;
  assign tx_valid_out = q.tx_valid;
  assign tx_soc_out = q.tx_soc;
  assign port_status_parity_out = q.perr;
endmodule : utx_phy_end

// *** logic/utx_atm_end.sv ***
// layer controller end: apb-programmed single-cell sender that makes the link clock
`timescale 1ns/1ps
module utx_atm_end
  import utx_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  utx_link_if.atm link,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  typedef struct packed {
    logic [2:0] div;
    logic ut_clk;
    logic [4:0] addr;
    logic enb_n;
    logic soc;
    logic [7:0] data;
    logic prty;
    utx_atm_state_e st;
    logic [5:0] idx;
    logic [31:0] ctrl;
    logic [31:0] hdr;
    logic [7:0] seed;
    logic go;
    logic refused;
    logic [7:0] sent;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } utx_atm_state_s;

  utx_atm_state_s q;
  utx_atm_state_s d;

  always_comb
  begin
    logic rise;
    logic fall;
    logic clav;
    logic [7:0] nb;
    logic mapped;
    d = q;
    // link clock from a divider; outputs change on its falling edge, the far end samples on the rising
    d.div = (q.div == LINK_FALL_CNT) ? 3'h0 : 3'(q.div + 3'h1);
    rise = (q.div == LINK_RISE_CNT);
    fall = (q.div == LINK_FALL_CNT);
    if (rise)
    begin
      d.ut_clk = 1'b1;
    end
    else if (fall)
    begin
      d.ut_clk = 1'b0;
    end
    clav = q.ctrl[CTRL_DIRECT_BIT] ? link.ut_clav_direct[q.ctrl[CTRL_PORT_LSB +: 2]] : link.ut_clav_level;
    nb = (q.idx < HEC_IDX) ? q.hdr[8'(31 - 8 * q.idx) -: 8] :
         (q.idx == HEC_IDX) ? 8'h00 : 8'(q.seed + {2'h0, q.idx});
    case (q.st)
      ATM_IDLE:
      begin
        if (q.go && fall)
        begin
          d.go = 1'b0;
          d.addr = q.ctrl[CTRL_PORT_LSB +: 5];
          d.enb_n = 1'b1;
          d.st = ATM_POLL;
        end
      end
      ATM_POLL:
      begin
        if (rise)
        begin
          d.st = ATM_WAIT;
        end
      end
      ATM_WAIT:
      begin
        // answer belongs to the address sampled one link cycle earlier
        if (rise)
        begin
          d.refused = ~clav;
          d.st = clav ? ATM_SEL : ATM_IDLE;
        end
      end
      ATM_SEL:
      begin
        if (fall)
        begin
          d.addr = q.ctrl[CTRL_PORT_LSB +: 5];
          d.enb_n = 1'b1;
          d.idx = CELL_FIRST_IDX;
          d.st = ATM_XFER;
        end
      end
      ATM_XFER:
      begin
        // whole cell without pause, so no other port can be held up
        if (fall)
        begin
          d.enb_n = 1'b0;
          d.soc = (q.idx == CELL_FIRST_IDX);
          d.data = nb;
          d.prty = (^nb) ^ q.ctrl[CTRL_ODD_BIT];
          d.idx = 6'(q.idx + 6'h1);
          if (q.idx == CELL_LAST_IDX)
          begin
            d.st = ATM_END;
          end
        end
      end
      ATM_END:
      begin
        if (fall)
        begin
          d.enb_n = 1'b1;
          d.soc = 1'b0;
          d.sent = 8'(q.sent + 8'h1);
          d.st = ATM_IDLE;
        end
      end
      default:
      begin
        d.st = ATM_IDLE;
      end
    endcase
    // apb: answer prepared in the setup cycle, so every access has zero wait states
    mapped = (paddr_in == REG_CTRL) || (paddr_in == REG_HDR) || (paddr_in == REG_SEED) ||
             (paddr_in == REG_GO) || (paddr_in == REG_STATUS);
    d.pready = 1'b0;
    if (psel_in && !penable_in)
    begin
      d.pready = 1'b1;
      d.pslverr = ~mapped;
      case (paddr_in)
        REG_CTRL: d.prdata = q.ctrl;
        REG_HDR: d.prdata = q.hdr;
        REG_SEED: d.prdata = {24'h0, q.seed};
        REG_STATUS: d.prdata = {16'h0, q.sent, 6'h0, q.refused, (q.st != ATM_IDLE) | q.go};
        default: d.prdata = 32'h0;
      endcase
    end
    if (psel_in && penable_in && q.pready && pwrite_in)
    begin
      case (paddr_in)
        REG_CTRL: d.ctrl = pwdata_in;
        REG_HDR: d.hdr = pwdata_in;
        REG_SEED: d.seed = pwdata_in[7:0];
        REG_GO: d.go = (q.st == ATM_IDLE) ? 1'b1 : q.go;
        default: d.go = q.go;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '0;
      q.enb_n <= 1'b1;
      q.addr <= NULL_ADDR;
      q.ctrl <= CTRL_RESET;
      q.hdr <= HDR_RESET;
      q.st <= ATM_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.ut_clk = q.ut_clk;
  assign link.ut_addr = q.addr;
  assign link.ut_enb_n = q.enb_n;
  assign link.ut_soc = q.soc;
  assign link.ut_data = q.data;
  assign link.ut_prty = q.prty;
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
endmodule : utx_atm_end

// *** verif/utx_link_properties.sv ***
// link-level properties watched beside the interface that joins the two ends
`timescale 1ns/1ps
module utx_link_properties
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ut_clk,
  input wire logic [4:0] ut_addr,
  input wire logic ut_enb_n,
  input wire logic ut_soc,
  input wire logic [7:0] ut_data,
  input wire logic ut_clav_oe_n
);
  logic [9:0] low_cnt_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // a counter, because a cell lasts far more cycles than a repetition can unroll
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      low_cnt_q <= 10'h000;
    else if (!ut_enb_n)
      low_cnt_q <= low_cnt_q + 10'h001;
    else
      low_cnt_q <= 10'h000;
  end
  a_link_clk_shape: assert property ($rose(ut_clk) |-> ut_clk [*4] ##1 !ut_clk)
    else $error("link clock high phase is not four cycles");
  a_clav_answer_time: assert property ($changed(ut_clav_oe_n) |-> $past(ut_clk, 3) && !$past(ut_clk, 4))
    else $error("shared status drive changed off its slot");
  a_clav_in_range: assert property ($fell(ut_clav_oe_n) |-> ut_addr != 5'h1f)
    else $error("null address answered");
  a_soc_in_enable: assert property (ut_soc |-> !ut_enb_n)
    else $error("start of cell outside enable");
  a_soc_one_byte: assert property ($rose(ut_soc) |-> ut_soc [*8] ##1 !ut_soc)
    else $error("start of cell not one link cycle");
  a_cell_length: assert property ($rose(ut_enb_n) |-> low_cnt_q == 10'h1a8)
    else $error("cell not 53 link cycles");
  a_addr_before_enb: assert property ($fell(ut_enb_n) |-> $past(ut_addr) != 5'h1f && $past(ut_enb_n, 8))
    else $error("enable without address presented first");
  a_enb_on_fall: assert property ($changed(ut_enb_n) |-> $fell(ut_clk))
    else $error("enable moved off the link falling edge");
  a_data_on_fall: assert property ($changed(ut_data) |-> $fell(ut_clk))
    else $error("data moved off the link falling edge");
endmodule : utx_link_properties

// *** verif/utopia_tx_cell_path_tb_top.sv ***
// self-checking bench: controller and port group joined over the link, driven through apb
`timescale 1ns/1ps
module utopia_tx_cell_path_tb_top
  import utx_pkg::*;
  ;
  localparam logic [31:0] HDR_A = 32'h1234_5670;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdw;
  logic pready_out, pslverr_out, e;
  logic [1:0] range_sel_in = 2'h0, depth_sel_in = 2'h0;
  logic direct_status_mode_in = 1'b0, transmit_parity_select_in = 1'b0;
  logic [7:0] parity_error_clear_in = 8'h00;
  logic hec_insert_enable_in = 1'b1, hec_coset_enable_in = 1'b1, idle_cell_coset_select_in = 1'b0;
  logic payload_scramble_enable_in = 1'b0, hec_error_insert_enable_in = 1'b0;
  logic [7:0] hec_error_pattern_periods_on_in = 8'h00, hec_error_pattern_periods_off_in = 8'h00;
  logic rd_req_in = 1'b0;
  logic [2:0] rd_port_in = 3'h0;
  logic [7:0] tx_byte_out, port_status_parity_out, hb1, hb2;
  logic tx_valid_out, tx_soc_out;
  int n_fail = 0, tests_run = 0;
  utx_link_if link_if();
  utx_atm_end utx_atm_end_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link_if), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
  utx_phy_end utx_phy_end_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link_if),
    .range_sel_in(range_sel_in), .depth_sel_in(depth_sel_in), .direct_status_mode_in(direct_status_mode_in),
    .transmit_parity_select_in(transmit_parity_select_in), .parity_error_clear_in(parity_error_clear_in),
    .hec_insert_enable_in(hec_insert_enable_in), .hec_coset_enable_in(hec_coset_enable_in),
    .idle_cell_coset_select_in(idle_cell_coset_select_in), .payload_scramble_enable_in(payload_scramble_enable_in),
    .hec_error_insert_enable_in(hec_error_insert_enable_in),
    .hec_error_pattern_periods_on_in(hec_error_pattern_periods_on_in),
    .hec_error_pattern_periods_off_in(hec_error_pattern_periods_off_in), .rd_req_in(rd_req_in),
    .rd_port_in(rd_port_in), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out), .tx_soc_out(tx_soc_out),
    .port_status_parity_out(port_status_parity_out));
  utx_link_properties utx_link_properties_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .ut_clk(link_if.ut_clk),
    .ut_addr(link_if.ut_addr), .ut_enb_n(link_if.ut_enb_n), .ut_soc(link_if.ut_soc), .ut_data(link_if.ut_data),
    .ut_clav_oe_n(link_if.ut_clav_oe_n));
  always #50 clk_in = ~clk_in;
  function automatic logic [7:0] crc8(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr
  task automatic send_cell(input logic [31:0] ctrl, input logic [31:0] hdr, input logic [7:0] seed, input logic refused);
    logic [31:0] st;
    logic er;
    wr(REG_CTRL, ctrl);
    wr(REG_HDR, hdr);
    wr(REG_SEED, {24'h0, seed});
    wr(REG_GO, 32'h1);
    do apb(1'b0, REG_STATUS, 32'h0, st, er); while (st[0] !== 1'b0);
    check("refused", {31'h0, refused}, {31'h0, st[1]});
  endtask : send_cell
  // pulls one whole cell out of a port and checks every byte, the header check byte only when chk_hec is set
  task automatic read_cell(input logic [2:0] p, input logic [31:0] hdr, input logic [7:0] seed, input logic idle,
    input logic [7:0] hec, input logic chk_hec, input logic scr, output logic [7:0] hb);
    logic [7:0] got [53];
    logic [7:0] pl;
    logic [42:0] s;
    s = '0;
    rd_port_in <= p;
    rd_req_in <= 1'b1;
    for (int i = 0; i < 54; i++)
    begin
      @(posedge clk_in);
      if (i == 52) rd_req_in <= 1'b0;
      if (i > 0)
      begin
        got[i - 1] = tx_byte_out;
        check("valid", 32'h1, {31'h0, tx_valid_out});
        check("soc", {31'h0, i == 1}, {31'h0, tx_soc_out});
      end
    end
    for (int k = 0; k < 4; k++) check("header", {24'h0, hdr[31 - 8 * k -: 8]}, {24'h0, got[k]});
    hb = got[4];
    if (chk_hec) check("hec", {24'h0, hec}, {24'h0, got[4]});
    for (int k = 5; k < 53; k++)
    begin
      pl = idle ? IDLE_PAYLOAD : seed + 8'(k);
      if (scr)
      begin
        for (int b = 7; b >= 0; b--)
        begin
          pl[b] = pl[b] ^ s[42];
          s = {s[41:0], pl[b]};
        end
      end
      check("payload", {24'h0, pl}, {24'h0, got[k]});
    end
  endtask : read_cell
  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1'b0, REG_CTRL, 32'h0, rdw, e);
    check("ctrl reset", CTRL_RESET, rdw);
    apb(1'b0, REG_HDR, 32'h0, rdw, e);
    check("hdr reset", HDR_RESET, rdw);
    apb(1'b0, 8'h14, 32'h0, rdw, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, rdw);
    // each depth setting takes exactly its number of cells, then refuses one
    for (int d = 0; d < 3; d++)
    begin
      depth_sel_in <= 2'(d);
      for (int c = 0; c <= d + 2; c++) send_cell(32'h2, HDR_A, 8'(c), c == d + 2);
      for (int c = 0; c < d + 2; c++) read_cell(3'h2, HDR_A, 8'(c), 1'b0, crc8(HDR_A) ^ 8'h55, 1'b1, 1'b0, hb1);
    end
    read_cell(3'h2, IDLE_HEADER, 8'h0, 1'b1, crc8(IDLE_HEADER), 1'b1, 1'b0, hb1);
    apb(1'b0, REG_STATUS, 32'h0, rdw, e);
    check("cells sent", 32'h0000_0902, rdw);
    check("no parity error", 32'h0, {24'h0, port_status_parity_out});
    for (int r = 1; r < 4; r++)
    begin
      range_sel_in <= 2'(r);
      hec_insert_enable_in <= (r != 1);
      hec_coset_enable_in <= (r == 3);
      send_cell(32'(r * 8 + 3), HDR_A, 8'h40, 1'b0);
      hb2 = (r == 1) ? 8'h00 : crc8(HDR_A) ^ ((r == 3) ? 8'h55 : 8'h00);
      read_cell(3'h3, HDR_A, 8'h40, 1'b0, hb2, 1'b1, 1'b0, hb1);
    end
    send_cell(32'h1f, HDR_A, 8'h40, 1'b1);
    range_sel_in <= 2'h0;
    send_cell(32'h9, HDR_A, 8'h40, 1'b1);
    payload_scramble_enable_in <= 1'b1;
    send_cell(32'h5, HDR_A, 8'h50, 1'b0);
    read_cell(3'h5, HDR_A, 8'h50, 1'b0, crc8(HDR_A) ^ 8'h55, 1'b1, 1'b1, hb1);
    payload_scramble_enable_in <= 1'b0;
    transmit_parity_select_in <= 1'b1;
    send_cell(32'h6, HDR_A, 8'h60, 1'b0);
    check("parity flag", 32'h40, {24'h0, port_status_parity_out});
    parity_error_clear_in <= 8'h40;
    @(posedge clk_in);
    parity_error_clear_in <= 8'h00;
    @(posedge clk_in);
    check("parity cleared", 32'h0, {24'h0, port_status_parity_out});
    send_cell(32'h206, HDR_A, 8'h61, 1'b0);
    check("odd parity clean", 32'h0, {24'h0, port_status_parity_out});
    // one errored cell, one clean, then every cell once the clean span is zero
    idle_cell_coset_select_in <= 1'b1;
    hec_error_pattern_periods_on_in <= 8'h01;
    hec_error_pattern_periods_off_in <= 8'h01;
    hec_error_insert_enable_in <= 1'b1;
    read_cell(3'h7, IDLE_HEADER, 8'h0, 1'b1, 8'h00, 1'b0, 1'b0, hb1);
    read_cell(3'h7, IDLE_HEADER, 8'h0, 1'b1, 8'h00, 1'b0, 1'b0, hb2);
    check("error alternates", 32'h1, {24'h0, hb1 ^ hb2});
    check("idle coset", {24'h0, (crc8(IDLE_HEADER) ^ 8'h55) & 8'hfe}, {24'h0, hb1 & 8'hfe});
    hec_error_pattern_periods_off_in <= 8'h00;
    read_cell(3'h7, IDLE_HEADER, 8'h0, 1'b1, crc8(IDLE_HEADER) ^ 8'h54, 1'b1, 1'b0, hb1);
    hec_error_insert_enable_in <= 1'b0;
    depth_sel_in <= 2'h0;
    direct_status_mode_in <= 1'b1;
    range_sel_in <= 2'h2;
    send_cell(32'h111, HDR_A, 8'h70, 1'b0);
    check("direct status", 32'hf, {28'h0, link_if.ut_clav_direct});
    send_cell(32'h111, HDR_A, 8'h71, 1'b0);
    check("direct status full", 32'hd, {28'h0, link_if.ut_clav_direct});
    final_report();
  end
endmodule : utopia_tx_cell_path_tb_top
